// ---- verilog/scr_pkg.sv ----
// Shared constants, types and state encoding for the synthesizer configuration block
package scr_pkg;

	// Register offsets of the three-byte configuration file
	localparam logic [1:0] ADDR_FEEDBACK_DIV_LOW        = 2'h0;
	localparam logic [1:0] ADDR_FEEDBACK_HIGH_POST_DIVS = 2'h1;
	localparam logic [1:0] ADDR_PREDIVIDER_AND_STATUS   = 2'h2;
	localparam logic [1:0] REG_COUNT                    = 2'h3;

	// Register reset values
	localparam logic [7:0] RST_FEEDBACK_DIV_LOW        = 8'h71;
	localparam logic [7:0] RST_FEEDBACK_HIGH_POST_DIVS = 8'h80;
	localparam logic [7:0] RST_PREDIVIDER_AND_STATUS   = 8'h80;

	// Field positions inside the bytes
	localparam int FB_HIGH_MSB = 7;
	localparam int FB_HIGH_LSB = 6;
	localparam int POST_A_MSB  = 5;
	localparam int POST_A_LSB  = 3;
	localparam int POST_B_MSB  = 2;
	localparam int POST_B_LSB  = 0;
	localparam int PRE_SEL_BIT = 7;
	localparam int RSV_MSB     = 6;
	localparam int RSV_LSB     = 3;
	localparam int LOCK_BIT    = 2;

	// Serial slave address prefix, upper five of seven bits
	localparam logic [4:0] SLAVE_PREFIX = 5'h16;

	// Bits per serial byte, as counted by the bit counter
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Post-divider code that stops the output low
	localparam logic [2:0] POST_STOP = 3'h7;

	// Pre-divider ratios
	localparam logic [2:0] PRE_RATIO_SEL0 = 3'h2;
	localparam logic [2:0] PRE_RATIO_SEL1 = 3'h4;

	// Active divider setting
	typedef struct packed {
		logic [9:0] fb_div;     // Feedback divider
		logic       pre_sel;    // Pre-divider select
		logic [2:0] post_div_a; // First output post-divider code
		logic [2:0] post_div_b; // Second output post-divider code
	} scr_cfg_t;

	// Default setting: feedback 625, pre-divide by 4, both post-divide by 1
	localparam scr_cfg_t CFG_DEFAULT = '{fb_div: 10'h271, pre_sel: 1'h1,
		post_div_a: 3'h0, post_div_b: 3'h0};

	// Slow control pins sampled from outside the clock domain
	typedef struct packed {
		logic       scl;                 // Serial clock
		logic       sda;                 // Serial data
		logic       pin_config_mode_n;   // Low: pins drive the dividers
		logic       chip_reset_n;        // Pin reset
		logic       lock;                // Raw lock from the loop
		logic [1:0] addr;                // Slave address pins
		logic       ref_crystal_osc;            // Reference select
		logic       pll_skip_test;       // Loop bypass
		logic       driver_level_choice; // Output level select
	} scr_ctrl_t;

	// Values the control synchroniser holds in reset
	localparam scr_ctrl_t CTRL_RST = '{scl: 1'h1, sda: 1'h1, pin_config_mode_n: 1'h0,
		chip_reset_n: 1'h0, lock: 1'h0, addr: 2'h0, ref_crystal_osc: 1'h1,
		pll_skip_test: 1'h0, driver_level_choice: 1'h0};

	// Serial slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK
	} scr_i2c_state_t;

endpackage

// ---- verilog/scr_sync3.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module scr_sync3 #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Raw and filtered levels
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] s1_ff;  // First stage, read only by the second
	logic [W-1:0] s2_ff;  // Second stage
	logic [W-1:0] s3_ff;  // Third stage
	logic [W-1:0] lvl_ff; // Accepted level
	wire  [W-1:0] agree_w = ~(s2_ff ^ s3_ff);

	// A bit changes only once stages two and three agree, so a single glitchy sample is dropped
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			lvl_ff <= RST_VAL;
		end else begin
			s1_ff  <= d_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= (s3_ff & agree_w) | (lvl_ff & ~agree_w);
		end
	end

	assign q_out = lvl_ff;

endmodule

// ---- verilog/scr_synth_cfg.sv ----
// Synthesizer configuration front end: serial slave, register file and pin mode
`timescale 1ns/1ns
module scr_synth_cfg (
	// Clock and power-on reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Device control pins
	input  wire logic              chip_reset_n_in,
	input  wire logic              pin_config_mode_n_in,
	input  wire logic [1:0]        addr_pin_in,
	input  wire scr_pkg::scr_cfg_t pin_cfg_in,
	input  wire logic              ref_sel_in,
	input  wire logic              pll_skip_test_in,
	input  wire logic              driver_level_choice_in,
	// Serial bus, data is open drain
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out_out,
	output logic                   sda_oe_out,
	// Loop status
	input  wire logic              pll_lock_in,
	output logic                   pll_locked_out,
	// Active divider setting towards the loop
	output scr_pkg::scr_cfg_t      active_cfg_out,
	output logic [2:0]             pre_ratio_out,
	output logic [4:0]             post_div_a_ratio_out,
	output logic [4:0]             post_div_b_ratio_out,
	output logic                   out_clk_first_stop_out,
	output logic                   out_clk_second_stop_out,
	// Reference, bypass and output level controls
	output logic                   ref_crystal_out,
	output logic                   pll_skip_test_out,
	output logic                   driver_level_choice_out
);

	// Post-divider code to ratio; zero means the output is held low
	function automatic logic [4:0] post_ratio(input logic [2:0] code);
		unique case (code)
			3'h0: post_ratio = 5'h01;
			3'h1: post_ratio = 5'h02;
			3'h2: post_ratio = 5'h03;
			3'h3: post_ratio = 5'h06;
			3'h4: post_ratio = 5'h04;
			3'h5: post_ratio = 5'h08;
			3'h6: post_ratio = 5'h10;
			3'h7: post_ratio = 5'h00;
		endcase
	endfunction

	// Read view of one register byte
	function automatic logic [7:0] rd_mux(input logic [1:0] idx, input scr_pkg::scr_cfg_t c,
		input logic lock, input logic [1:0] adr);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			scr_pkg::ADDR_FEEDBACK_DIV_LOW: b = c.fb_div[7:0];
			scr_pkg::ADDR_FEEDBACK_HIGH_POST_DIVS: b = {c.fb_div[9:8], c.post_div_a,
				c.post_div_b};
			scr_pkg::ADDR_PREDIVIDER_AND_STATUS: begin
				b[scr_pkg::PRE_SEL_BIT] = c.pre_sel;
				b[scr_pkg::LOCK_BIT] = lock;
				b[1:0] = adr;
			end
			default: b = 8'h00; // Unused index
		endcase
		rd_mux = b;
	endfunction

	// Synchronised control levels
	scr_pkg::scr_ctrl_t ctrl_raw_w;   // Raw pin bundle
	scr_pkg::scr_ctrl_t ctrl_w;       // Filtered pin bundle
	scr_pkg::scr_cfg_t  pin_lvl_w;    // Filtered divider pins

	assign ctrl_raw_w = '{scl: scl_in, sda: sda_in, pin_config_mode_n: pin_config_mode_n_in,
		chip_reset_n: chip_reset_n_in, lock: pll_lock_in, addr: addr_pin_in,
		ref_crystal_osc: ref_sel_in, pll_skip_test: pll_skip_test_in,
		driver_level_choice: driver_level_choice_in};

	// Control pins, including the serial clock, pass the agreement filter
	scr_sync3 #(
		.W       ($bits(scr_pkg::scr_ctrl_t)),
		.RST_VAL (scr_pkg::CTRL_RST)
	) u_ctrl_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (ctrl_raw_w),
		.q_out  (ctrl_w)
	);

	// Divider pins; reset value is the floating-pin default
	scr_sync3 #(
		.W       ($bits(scr_pkg::scr_cfg_t)),
		.RST_VAL (scr_pkg::CFG_DEFAULT)
	) u_pin_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (pin_cfg_in),
		.q_out  (pin_lvl_w)
	);

	// Edge history of the filtered levels
	logic scl_prev_ff;   // Serial clock last cycle
	logic sda_prev_ff;   // Serial data last cycle
	logic nmr_prev_ff;   // Pin reset last cycle

	// Serial slave state
	scr_pkg::scr_i2c_state_t state_ff, nxt_state;
	logic [3:0]         bit_cnt_ff, nxt_bit_cnt;     // Bits seen in this byte
	logic [7:0]         shift_ff, nxt_shift;         // Byte shifter
	logic [1:0]         idx_ff, nxt_idx;             // Byte index, saturates at three on writes
	logic               drive_ff, nxt_drive;         // Pulling data low
	logic               rw_ff, nxt_rw;               // Read transfer
	logic               nack_ff, nxt_nack;           // Host declined more data
	logic               addressed_ff, nxt_addressed; // Our address matched
	logic [7:0]         stage_ff [3];                // Write staging bytes
	logic [7:0]         nxt_stage [3];
	logic               sda_low_ff;                  // Open-drain data level

	// Register file and outputs
	scr_pkg::scr_cfg_t  cfg_ff, nxt_cfg;             // Register file is the active setting
	scr_pkg::scr_cfg_t  staged_w;                    // Setting assembled from staged bytes
	logic [2:0]         pre_ratio_ff;
	logic [4:0]         ratio_a_ff;
	logic [4:0]         ratio_b_ff;
	logic               ref_crystal_osc_ff;
	logic               skip_ff;
	logic               level_ff;

	// Decoded events
	wire scl_rise   = ctrl_w.scl & ~scl_prev_ff;
	wire scl_fall   = ~ctrl_w.scl & scl_prev_ff;
	wire start_det  = ctrl_w.scl & scl_prev_ff & ~ctrl_w.sda & sda_prev_ff;
	wire stop_det   = ctrl_w.scl & scl_prev_ff & ctrl_w.sda & ~sda_prev_ff;
	wire nmr_lvl    = ctrl_w.chip_reset_n;
	wire nmr_rise   = nmr_lvl & ~nmr_prev_ff;
	wire serial_md  = ctrl_w.pin_config_mode_n;
	wire byte_done  = (bit_cnt_ff == scr_pkg::BITS_PER_BYTE);
	wire addr_hit   = (shift_ff[7:1] == {scr_pkg::SLAVE_PREFIX, ctrl_w.addr});
	wire wr_full    = (idx_ff == scr_pkg::REG_COUNT);
	// Mode is assumed steady across a transfer, so it is sampled at the stop
	wire commit     = stop_det & addressed_ff & ~rw_ff & wr_full & serial_md;

	// Byte being sent and the one after it; reads wrap after the last byte
	wire [1:0] rd_next_idx = (idx_ff == scr_pkg::ADDR_PREDIVIDER_AND_STATUS) ?
		scr_pkg::ADDR_FEEDBACK_DIV_LOW : idx_ff + 2'h1;
	wire [7:0] rd_cur_w  = rd_mux(idx_ff, cfg_ff, ctrl_w.lock, ctrl_w.addr);
	wire [7:0] rd_next_w = rd_mux(rd_next_idx, cfg_ff, ctrl_w.lock, ctrl_w.addr);
	wire [7:0] rd_stat_w = rd_mux(scr_pkg::ADDR_PREDIVIDER_AND_STATUS, cfg_ff,
		ctrl_w.lock, ctrl_w.addr);

	// Staged bytes to a setting; status and reserved bits are dropped, no range check
	assign staged_w = '{
		fb_div: {stage_ff[scr_pkg::ADDR_FEEDBACK_HIGH_POST_DIVS][scr_pkg::FB_HIGH_MSB:
			scr_pkg::FB_HIGH_LSB], stage_ff[scr_pkg::ADDR_FEEDBACK_DIV_LOW]},
		pre_sel: stage_ff[scr_pkg::ADDR_PREDIVIDER_AND_STATUS][scr_pkg::PRE_SEL_BIT],
		post_div_a: stage_ff[scr_pkg::ADDR_FEEDBACK_HIGH_POST_DIVS][scr_pkg::POST_A_MSB:
			scr_pkg::POST_A_LSB],
		post_div_b: stage_ff[scr_pkg::ADDR_FEEDBACK_HIGH_POST_DIVS][scr_pkg::POST_B_MSB:
			scr_pkg::POST_B_LSB]};

	// Register file next value, reset first, then capture, pins, serial commit
	always_comb begin
		if (!nmr_lvl) begin
			nxt_cfg = scr_pkg::CFG_DEFAULT;
		end else if (nmr_rise) begin
			nxt_cfg = pin_lvl_w;
		end else if (!serial_md) begin
			nxt_cfg = pin_lvl_w;
		end else if (commit) begin
			nxt_cfg = staged_w;
		end else begin
			nxt_cfg = cfg_ff;
		end
	end

	// Register file and decoded ratios follow the same next value, so they never disagree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_ff       <= scr_pkg::CFG_DEFAULT;
			pre_ratio_ff <= scr_pkg::PRE_RATIO_SEL1;
			ratio_a_ff   <= 5'h01;
			ratio_b_ff   <= 5'h01;
		end else begin
			cfg_ff       <= nxt_cfg;
			pre_ratio_ff <= nxt_cfg.pre_sel ? scr_pkg::PRE_RATIO_SEL1 :
				scr_pkg::PRE_RATIO_SEL0;
			ratio_a_ff   <= post_ratio(nxt_cfg.post_div_a);
			ratio_b_ff   <= post_ratio(nxt_cfg.post_div_b);
		end
	end

	// Static controls, registered after the filter
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ref_crystal_osc_ff <= 1'h1;
			skip_ff     <= 1'h0;
			level_ff    <= 1'h0;
		end else begin
			ref_crystal_osc_ff <= ctrl_w.ref_crystal_osc;
			skip_ff     <= ctrl_w.pll_skip_test;
			level_ff    <= ctrl_w.driver_level_choice;
		end
	end

	// Edge history
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_prev_ff <= 1'h1;
			sda_prev_ff <= 1'h1;
			nmr_prev_ff <= 1'h0;
		end else begin
			scl_prev_ff <= ctrl_w.scl;
			sda_prev_ff <= ctrl_w.sda;
			nmr_prev_ff <= nmr_lvl;
		end
	end

	// Serial slave: sample on clock rise, change the data line on clock fall
	always_comb begin
		nxt_state     = state_ff;
		nxt_bit_cnt   = bit_cnt_ff;
		nxt_shift     = shift_ff;
		nxt_idx       = idx_ff;
		nxt_drive     = drive_ff;
		nxt_rw        = rw_ff;
		nxt_nack      = nack_ff;
		nxt_addressed = addressed_ff;
		nxt_stage     = stage_ff;
		if (start_det) begin
			// Every transfer restarts at byte 0
			nxt_state     = scr_pkg::ST_ADDR;
			nxt_bit_cnt   = 4'h0;
			nxt_idx       = scr_pkg::ADDR_FEEDBACK_DIV_LOW;
			nxt_drive     = 1'h0;
			nxt_addressed = 1'h0;
		end else if (stop_det) begin
			nxt_state     = scr_pkg::ST_IDLE;
			nxt_drive     = 1'h0;
			nxt_addressed = 1'h0;
		end else if (scl_rise) begin
			unique case (state_ff)
				scr_pkg::ST_ADDR, scr_pkg::ST_WR_BYTE: begin
					nxt_shift   = {shift_ff[6:0], ctrl_w.sda};
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
				end
				scr_pkg::ST_RD_BYTE: begin
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
				end
				scr_pkg::ST_RD_ACK: begin
					nxt_nack = ctrl_w.sda;
				end
				scr_pkg::ST_IDLE, scr_pkg::ST_ADDR_ACK, scr_pkg::ST_WR_ACK: begin
					nxt_nack = nack_ff;
				end
			endcase
		end else if (scl_fall) begin
			unique case (state_ff)
				scr_pkg::ST_IDLE: begin
					nxt_drive = 1'h0;
				end
				scr_pkg::ST_ADDR: begin
					if (byte_done && addr_hit) begin
						nxt_state     = scr_pkg::ST_ADDR_ACK;
						nxt_drive     = 1'h1;
						nxt_rw        = shift_ff[0];
						nxt_addressed = 1'h1;
					end else if (byte_done) begin
						nxt_state = scr_pkg::ST_IDLE;
					end
				end
				scr_pkg::ST_ADDR_ACK: begin
					nxt_bit_cnt = 4'h0;
					if (rw_ff) begin
						nxt_state = scr_pkg::ST_RD_BYTE;
						nxt_shift = rd_cur_w;
						nxt_drive = ~rd_cur_w[7];
					end else begin
						nxt_state = scr_pkg::ST_WR_BYTE;
						nxt_drive = 1'h0;
					end
				end
				scr_pkg::ST_WR_BYTE: begin
					if (byte_done) begin
						// Acknowledged in both modes; extra bytes are dropped
						nxt_state   = scr_pkg::ST_WR_ACK;
						nxt_drive   = 1'h1;
						nxt_bit_cnt = 4'h0;
						if (!wr_full) begin
							nxt_stage[idx_ff] = shift_ff;
							nxt_idx           = idx_ff + 2'h1;
						end
					end
				end
				scr_pkg::ST_WR_ACK: begin
					nxt_state = scr_pkg::ST_WR_BYTE;
					nxt_drive = 1'h0;
				end
				scr_pkg::ST_RD_BYTE: begin
					if (byte_done) begin
						nxt_state = scr_pkg::ST_RD_ACK;
						nxt_drive = 1'h0;
					end else begin
						nxt_shift = {shift_ff[6:0], 1'h0};
						nxt_drive = ~shift_ff[6];
					end
				end
				scr_pkg::ST_RD_ACK: begin
					if (nack_ff) begin
						nxt_state = scr_pkg::ST_IDLE;
						nxt_drive = 1'h0;
					end else begin
						nxt_state   = scr_pkg::ST_RD_BYTE;
						nxt_bit_cnt = 4'h0;
						nxt_idx     = rd_next_idx;
						nxt_shift   = rd_next_w;
						nxt_drive   = ~rd_next_w[7];
					end
				end
			endcase
		end
	end

	// Slave registers; the pin reset also returns the bus side to idle
	always_ff @(posedge clk_in) begin
		if (rst_in || !nmr_lvl) begin
			state_ff     <= scr_pkg::ST_IDLE;
			bit_cnt_ff   <= 4'h0;
			shift_ff     <= 8'h00;
			idx_ff       <= 2'h0;
			drive_ff     <= 1'h0;
			rw_ff        <= 1'h0;
			nack_ff      <= 1'h0;
			addressed_ff <= 1'h0;
			stage_ff     <= '{scr_pkg::RST_FEEDBACK_DIV_LOW, scr_pkg::RST_FEEDBACK_HIGH_POST_DIVS,
				scr_pkg::RST_PREDIVIDER_AND_STATUS};
			sda_low_ff   <= 1'h0;
		end else begin
			state_ff     <= nxt_state;
			bit_cnt_ff   <= nxt_bit_cnt;
			shift_ff     <= nxt_shift;
			idx_ff       <= nxt_idx;
			drive_ff     <= nxt_drive;
			rw_ff        <= nxt_rw;
			nack_ff      <= nxt_nack;
			addressed_ff <= nxt_addressed;
			stage_ff     <= nxt_stage;
			sda_low_ff   <= 1'h0;
		end
	end

	// Outputs
	assign sda_out_out             = sda_low_ff;
	assign sda_oe_out              = drive_ff;
	assign pll_locked_out          = ctrl_w.lock;
	assign active_cfg_out          = cfg_ff;
	assign pre_ratio_out           = pre_ratio_ff;
	assign post_div_a_ratio_out    = ratio_a_ff;
	assign post_div_b_ratio_out    = ratio_b_ff;
	assign out_clk_first_stop_out  = (ratio_a_ff == 5'h00);
	assign out_clk_second_stop_out = (ratio_b_ff == 5'h00);
	assign ref_crystal_out         = ref_crystal_osc_ff;
	assign pll_skip_test_out       = skip_ff;
	assign driver_level_choice_out = level_ff;

	// Checks on the design's own behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Last address bit clocked in and matched
	sequence seq_addr_match;
		state_ff == scr_pkg::ST_ADDR && scl_fall && byte_done && addr_hit;
	endsequence

	// Acknowledge driven for two cycles in the acknowledge state
	sequence seq_ack_held;
		(state_ff == scr_pkg::ST_ADDR_ACK && sda_oe_out)[*2];
	endsequence

	AST_RST_DEFAULT: assert property (!nmr_lvl |=> cfg_ff == scr_pkg::CFG_DEFAULT)
		else $error("Register file left defaults during pin reset");
	AST_CAPTURE: assert property (nmr_rise |=> cfg_ff == $past(pin_lvl_w))
		else $error("Pin setting not captured at reset release");
	AST_PIN_FOLLOW: assert property (nmr_lvl && !serial_md |=> cfg_ff == $past(pin_lvl_w))
		else $error("Pin mode did not follow the divider pins");
	AST_NO_PARTIAL: assert property (nmr_lvl && $past(nmr_lvl) && serial_md && !commit
		|=> $stable(cfg_ff))
		else $error("Dividers changed without a completed write");
	AST_COMMIT: assert property (commit && nmr_lvl && !nmr_rise |=> cfg_ff == $past(staged_w))
		else $error("Completed write not applied");
	AST_MODE_KEEP: assert property ($rose(serial_md) && nmr_lvl && $past(nmr_lvl)
		|=> cfg_ff == $past(cfg_ff))
		else $error("Switch to serial mode changed the setting");
	AST_STATUS_BITS: assert property (rd_stat_w[scr_pkg::LOCK_BIT] == pll_locked_out
		&& rd_stat_w[scr_pkg::RSV_MSB:scr_pkg::RSV_LSB] == 4'h0
		&& rd_stat_w[1:0] == ctrl_w.addr)
		else $error("Status byte disagrees with lock, reserved or address");
	AST_ADDR_ACK: assert property (seq_addr_match ##1 !stop_det && !start_det && !scl_fall
		|-> seq_ack_held)
		else $error("Matching address not acknowledged");
	AST_WR_ACK: assert property (state_ff == scr_pkg::ST_WR_BYTE && scl_fall && byte_done
		&& !start_det && !stop_det |=> sda_oe_out && state_ff == scr_pkg::ST_WR_ACK)
		else $error("Write byte not acknowledged");
	AST_STOP_IDLE: assert property (stop_det && nmr_lvl |=> state_ff == scr_pkg::ST_IDLE
		&& !sda_oe_out)
		else $error("Stop did not return the slave to idle");
	AST_RD_FIRST: assert property (state_ff == scr_pkg::ST_ADDR_ACK && rw_ff && scl_fall
		&& !start_det && !stop_det |=> shift_ff == $past(rd_cur_w))
		else $error("Read did not load the current byte");

endmodule

// ---- dv/scr_i2c_host.sv ----
// Serial bus host model: drives the clock, pulls the open-drain data line
`timescale 1ns/1ns
module scr_i2c_host (
	// Bus lines
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      pull_out
);
	// Idle bus: clock high and data released, clock stands still between frames
	initial begin
		scl_out = 1'h1;
		pull_out = 1'h0;
	end
	// One bit; the low phase is long because the slave answers a filter delay after the fall,
	// and its answer must settle in its own filtered view before the clock rises there
	task automatic bit_xfer(input logic b, output logic r);
		scl_out = 1'h0;
		#80 pull_out = !b;
		#160 scl_out = 1'h1;
		#40 r = sda_in;
		#40;
	endtask
	// Start, also usable as a repeated start
	task automatic start();
		scl_out = 1'h0;
		#160 pull_out = 1'h0;
		#80 scl_out = 1'h1;
		#80 pull_out = 1'h1;
		#80;
	endtask
	// Stop: data rises while clock high
	task automatic stop();
		scl_out = 1'h0;
		#160 pull_out = 1'h1;
		#80 scl_out = 1'h1;
		#80 pull_out = 1'h0;
		#160;
	endtask
	// Byte out, MSB first, then the slave's acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
		bit_xfer(1'h1, r);
		ack = !r;
	endtask
	// Byte in; the last byte is refused so the slave lets go
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(1'h1, d[i]);
		bit_xfer(last, r);
	endtask
	// Whole frame; byte 0 of the file sits in d[23:16]
	task automatic frame(input logic rd, input logic [6:0] a, input int n, input logic stp,
		inout logic [23:0] d, output logic ack);
		logic k;
		start();
		put_byte({a, rd}, ack);
		for (int i = 0; i < n; i++) begin
			if (rd) get_byte(i == n - 1, d[23-8*i -: 8]);
			else put_byte(d[23-8*i -: 8], k);
		end
		if (stp) stop();
	endtask
endmodule

// ---- dv/test_scr_synth_cfg.sv ----
// Self-checking bench for the synthesizer configuration block
`timescale 1ns/1ns
module test_scr_synth_cfg;
	logic clk, rst, crn_n, mode_n, rsel, skip, lvl, lock_in, scl, pull, oe, sda, ack;
	logic [1:0] adr;                    // Address pins
	scr_pkg::scr_cfg_t pin, act, c;     // Pin and active settings
	logic [2:0] pr;                     // Decoded outputs
	logic [4:0] ra, rb;
	logic sa, sb, lk, ro, so, lo, sdo;
	logic [23:0] d, w;                  // Byte images
	int fails, checks;
	// Post-divider ratio per code; stop code gives zero
	localparam logic [4:0] RT [8] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h04, 5'h08, 5'h10, 5'h00};
	assign sda = !(pull | oe); // Pulled-up wire
	scr_synth_cfg dut (.clk_in(clk), .rst_in(rst), .chip_reset_n_in(crn_n),
		.pin_config_mode_n_in(mode_n), .addr_pin_in(adr), .pin_cfg_in(pin),
		.ref_sel_in(rsel), .pll_skip_test_in(skip), .driver_level_choice_in(lvl),
		.scl_in(scl), .sda_in(sda), .sda_out_out(sdo), .sda_oe_out(oe), .pll_lock_in(lock_in),
		.pll_locked_out(lk), .active_cfg_out(act), .pre_ratio_out(pr),
		.post_div_a_ratio_out(ra), .post_div_b_ratio_out(rb), .out_clk_first_stop_out(sa),
		.out_clk_second_stop_out(sb), .ref_crystal_out(ro), .pll_skip_test_out(so),
		.driver_level_choice_out(lo));
	scr_i2c_host host (.sda_in(sda), .scl_out(scl), .pull_out(pull));
	// 25 MHz clock
	initial begin
		clk = 1'h0;
		forever #20 clk = !clk;
	end
	// Setting carried by a written byte image
	function automatic scr_pkg::scr_cfg_t cfg_of(logic [23:0] b);
		return {b[15:14], b[23:16], b[7], b[13:8]};
	endfunction
	// Byte image a read should return
	function automatic logic [23:0] img(scr_pkg::scr_cfg_t s, logic l);
		return {s.fb_div[7:0], s.fb_div[9:8], s.post_div_a, s.post_div_b, s.pre_sel, 4'h0, l, adr};
	endfunction
	// Compare and count
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Active setting and its decoded ratios
	task automatic cfg_chk(input string nm, input scr_pkg::scr_cfg_t s);
		repeat (12) @(negedge clk);
		chk(nm, 24'(s), 24'(act));
		chk(nm, {9'h0, s.pre_sel ? 3'h4 : 3'h2, RT[s.post_div_a], RT[s.post_div_b],
			s.post_div_a == 3'h7, s.post_div_b == 3'h7}, {9'h0, pr, ra, rb, sa, sb});
		chk("pass", {rsel, skip, lvl, lock_in, 1'h0}, {ro, so, lo, lk, sdo});
	endtask
	// Read the file and compare with the expected image
	task automatic rd_chk(input scr_pkg::scr_cfg_t s);
		host.frame(1'h1, {5'h16, adr}, 3, 1'h1, d, ack);
		chk("read ack", 24'h1, 24'(ack));
		chk("read", img(s, lock_in), d);
	endtask
	// Verdict
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		fails++;
		close_out();
	end
	// Main sequence
	initial begin
		fails = 0;
		checks = 0;
		void'($urandom(32'had8854bd));
		{rst, crn_n, mode_n, lock_in} = 4'he;
		adr = 2'($urandom);
		pin = 17'($urandom);
		{rsel, skip, lvl} = 3'($urandom);
		repeat (20) @(negedge clk);
		rst = 1'h0;
		cfg_chk("capture", pin);
		rd_chk(pin);
		// Wrong address is ignored
		w = 24'($urandom);
		host.frame(1'h0, {5'h16, ~adr}, 3, 1'h1, w, ack);
		chk("no ack", 24'h0, 24'(ack));
		cfg_chk("foreign", pin);
		// Full write takes effect only at stop, unchecked values too
		host.frame(1'h0, {5'h16, adr}, 3, 1'h0, w, ack);
		chk("write ack", 24'h1, 24'(ack));
		cfg_chk("pre stop", pin);
		host.stop();
		lock_in = 1'h1;
		cfg_chk("written", cfg_of(w));
		rd_chk(cfg_of(w));
		// Short write changes nothing
		d = 24'($urandom);
		host.frame(1'h0, {5'h16, adr}, 2, 1'h1, d, ack);
		cfg_chk("short", cfg_of(w));
		// Pin mode follows pins and discards writes
		mode_n = 1'h0;
		cfg_chk("to pins", pin);
		host.frame(1'h0, {5'h16, adr}, 3, 1'h1, d, ack);
		chk("pin ack", 24'h1, 24'(ack));
		cfg_chk("discard", pin);
		for (int i = 0; i < 8; i++) begin
			pin = 17'($urandom);
			pin.post_div_a = 3'(i);
			pin.post_div_b = 3'(7 - i);
			{rsel, skip, lvl, lock_in} = 4'($urandom);
			cfg_chk("follow", pin);
		end
		rd_chk(pin);
		// Back to serial keeps the setting
		c = pin;
		mode_n = 1'h1;
		pin = 17'($urandom);
		cfg_chk("keep", c);
		// Pin reset loads defaults, release captures pins
		crn_n = 1'h0;
		cfg_chk("reset", scr_pkg::CFG_DEFAULT);
		crn_n = 1'h1;
		cfg_chk("release", pin);
		close_out();
	end
endmodule
